// ===== pmia_auth.sv
// pmia_auth: registered debug authentication status word.
// assumes the permission inputs are synchronous to mclk.
`timescale 1ns/1ps
module pmia_auth #(
	parameter bit SEC_EXT = 1'b1
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic dbg_allow_in,
	input wire logic watch_allow_in,
	input wire logic trusted_dbg_allow_in,
	input wire logic trusted_watch_allow_in,
	output logic [31:0] status
);
	logic [31:0] next_status;
	wire logic open_on = dbg_allow_in | watch_allow_in;
	wire logic trusted_perm = trusted_dbg_allow_in | trusted_watch_allow_in;
	wire logic tw_on = SEC_EXT ? (open_on & trusted_perm)
		: open_on;
	wire logic ow_built = SEC_EXT;
	wire logic ow_on = SEC_EXT ? open_on : 1'b0;

	always_comb begin
		next_status = '0;
		next_status[pmia_pkg::AUTH_TW_BUILT] = 1'b1;
		next_status[pmia_pkg::AUTH_TW_ON] = tw_on;
		next_status[pmia_pkg::AUTH_OW_BUILT] = ow_built;
		next_status[pmia_pkg::AUTH_OW_ON] = ow_on;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			status <= pmia_pkg::AUTH_RST;
		end else begin
			status <= next_status;
		end
	end

	tw_off_a:
	assert property (@(posedge mclk) disable iff (rst)
		(!dbg_allow_in && !watch_allow_in) |=> !status[6])
		else $error("trusted watch on without open permission");

	tw_trust_a:
	assert property (@(posedge mclk) disable iff (rst)
		(SEC_EXT && !trusted_dbg_allow_in && !trusted_watch_allow_in)
		|=> !status[6])
		else $error("trusted watch on without trusted permission");

	ow_state_a:
	assert property (@(posedge mclk) disable iff (rst)
		!$past(rst) |-> (status[3] == SEC_EXT)
		&& (status[2] == (SEC_EXT && $past(dbg_allow_in | watch_allow_in))))
		else $error("open watch bits wrong");
endmodule

// ===== pmia_bitmap.sv
// pmia_bitmap: one set/clear counter bitmap, eight 32-bit words.
// assumes write strobes are one-cycle and word_idx is valid with them.
`timescale 1ns/1ps
module pmia_bitmap (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [7:0] cnt_n,
	input wire logic set_wr,
	input wire logic clr_wr,
	input wire logic [2:0] word_idx,
	input wire logic [31:0] wdata,
	input wire logic [255:0] hw_set,
	output logic [255:0] bits
);
	wire logic [255:0] next_bits;
	wire logic [255:0] impl_v;
	wire logic [31:0] word_impl = impl_v[word_idx*32 +: 32];
	wire logic [31:0] set_mask = wdata & word_impl;
	wire logic [31:0] hw_word = hw_set[word_idx*32 +: 32];

	genvar i;
	for (i = 0; i < pmia_pkg::BITMAP_BITS; i++) begin : g_bit
		// counter i lives in word i/32, bit i%32
		wire logic hit = (word_idx == 3'(i / 32)) && wdata[i % 32];
		assign impl_v[i] = (8'(i) <= cnt_n);
		// hardware set wins over a clear in the same cycle
		assign next_bits[i] = impl_v[i] &
			((bits[i] & ~(clr_wr & hit)) | (set_wr & hit) | hw_set[i]);
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			bits <= pmia_pkg::BITMAP_RST;
		end else begin
			bits <= next_bits;
		end
	end

	unimpl_zero_a:
	assert property (@(posedge mclk) disable iff (rst)
		(bits & ~impl_v) == '0)
		else $error("unimplemented bitmap bit is set");

	set_write_a:
	assert property (@(posedge mclk) disable iff (rst)
		set_wr |=> ((bits[$past(word_idx)*32 +: 32] & $past(set_mask))
			== $past(set_mask)))
		else $error("bitmap set write not taken");

	clr_write_a:
	assert property (@(posedge mclk) disable iff (rst)
		(clr_wr && !set_wr) |=> ((bits[$past(word_idx)*32 +: 32]
			& $past(set_mask) & ~$past(hw_word)) == '0))
		else $error("bitmap clear write not taken");
endmodule

// ===== pmia_pkg.sv
// pmia_pkg: offsets, field positions, reset values and carrier types
// for the monitor identity, authentication and bitmap register page.
// assumes byte addresses within one register page, word aligned.
package pmia_pkg;

	typedef struct packed {
		logic sel;
		logic wr;
		logic [15:0] addr;
		logic [31:0] wdata;
	} pmia_req_t;

	// bitmap banks, decoded on addr[15:5]
	localparam logic [10:0] BANK_CE_SET = 11'h060;
	localparam logic [10:0] BANK_CE_CLR = 11'h061;
	localparam logic [10:0] BANK_IE_SET = 11'h062;
	localparam logic [10:0] BANK_IE_CLR = 11'h063;
	localparam logic [10:0] BANK_OV_CLR = 11'h064;
	localparam logic [10:0] BANK_OV_SET = 11'h066;

	// single registers
	localparam logic [15:0] OFF_CFG = 16'h0e00;
	localparam logic [15:0] OFF_CEID_LO = 16'h0e20;
	localparam logic [15:0] OFF_CEID_HI = 16'h0e24;
	localparam logic [15:0] OFF_INTEG = 16'h0f00;
	localparam logic [15:0] OFF_AUTH = 16'h0fb8;
	localparam logic [15:0] OFF_DEVTYPE = 16'h0fcc;
	localparam logic [15:0] OFF_IDENT_LO = 16'h0fd0;
	localparam logic [15:0] OFF_IDENT_HI = 16'h0ffc;
	localparam logic [15:0] OFF_PAGE_TAIL = 16'h1000;

	// authentication status bit positions
	localparam int AUTH_TW_BUILT = 7;
	localparam int AUTH_TW_ON = 6;
	localparam int AUTH_TH_BUILT = 5;
	localparam int AUTH_TH_ON = 4;
	localparam int AUTH_OW_BUILT = 3;
	localparam int AUTH_OW_ON = 2;
	localparam int AUTH_OH_BUILT = 1;
	localparam int AUTH_OH_ON = 0;

	// event classes that may be reported: 18,17,16,10,9,8,1,0
	localparam logic [31:0] CEID0_MASK = 32'h0007_0703;
	localparam int CEID0_WRITE_EVT = 18;

	// configuration word fields
	localparam int CFG_SIZE_POS = 8;
	localparam logic [5:0] CFG_SIZE = 6'h1f;

	localparam int BITMAP_WORDS = 8;
	localparam int BITMAP_BITS = 256;
	localparam logic [255:0] BITMAP_RST = '0;
	localparam logic [31:0] AUTH_RST = 32'h0000_0000;
	localparam logic [31:0] RDATA_RST = 32'h0000_0000;

	// build defaults
	localparam logic [7:0] CNT_N_DFLT = 8'h23;
	localparam logic [31:0] EVENT_IMPL_DFLT = 32'h0007_0703;
	// identity values are arbitrary
	localparam logic [31:0] DEV_TYPE_DFLT = 32'h0000_0056;
	localparam logic [31:0] IDENT_BASE_DFLT = 32'h0000_00a0;

endpackage

// ===== pmia_top.sv
// pmia_top: monitor page upper map: identity, authentication,
// configuration word and the six counter bitmap banks.
// assumes one request per cycle at most on reg_req, synchronous inputs.
`timescale 1ns/1ps
module pmia_top #(
	parameter logic [7:0] CNT_N = pmia_pkg::CNT_N_DFLT,
	parameter bit SEC_EXT = 1'b1,
	parameter logic [31:0] EVENT_IMPL = pmia_pkg::EVENT_IMPL_DFLT,
	parameter logic [31:0] DEV_TYPE = pmia_pkg::DEV_TYPE_DFLT,
	parameter logic [31:0] IDENT_BASE = pmia_pkg::IDENT_BASE_DFLT
) (
	input wire logic mclk,
	input wire logic rst,
	input wire pmia_pkg::pmia_req_t reg_req,
	input wire logic dbg_allow_in,
	input wire logic watch_allow_in,
	input wire logic trusted_dbg_allow_in,
	input wire logic trusted_watch_allow_in,
	input wire logic [255:0] ovf_event,
	output logic [31:0] reg_rdata,
	output logic reg_ack,
	output logic [255:0] count_enable,
	output logic [255:0] irq_enable,
	output logic [255:0] overflow_status
);
	logic [31:0] auth_status;
	logic [31:0] next_rdata;

	// request decode
	wire logic [15:0] waddr = {reg_req.addr[15:2], 2'b00};
	wire logic [10:0] bank = waddr[15:5];
	wire logic [2:0] widx = waddr[4:2];
	wire logic rd_req = reg_req.sel & ~reg_req.wr;
	wire logic wr_req = reg_req.sel & reg_req.wr;

	wire logic hit_ce_set = (bank == pmia_pkg::BANK_CE_SET);
	wire logic hit_ce_clr = (bank == pmia_pkg::BANK_CE_CLR);
	wire logic hit_ie_set = (bank == pmia_pkg::BANK_IE_SET);
	wire logic hit_ie_clr = (bank == pmia_pkg::BANK_IE_CLR);
	wire logic hit_ov_clr = (bank == pmia_pkg::BANK_OV_CLR);
	wire logic hit_ov_set = (bank == pmia_pkg::BANK_OV_SET);
	wire logic hit_ce = hit_ce_set | hit_ce_clr;
	wire logic hit_ie = hit_ie_set | hit_ie_clr;
	wire logic hit_ov = hit_ov_set | hit_ov_clr;

	// bank write strobes, one per set or clear view
	wire logic wr_ce_set = wr_req & hit_ce_set;
	wire logic wr_ce_clr = wr_req & hit_ce_clr;
	wire logic wr_ie_set = wr_req & hit_ie_set;
	wire logic wr_ie_clr = wr_req & hit_ie_clr;
	wire logic wr_ov_set = wr_req & hit_ov_set;
	wire logic wr_ov_clr = wr_req & hit_ov_clr;
	wire logic [2:0] top_word = 3'(CNT_N / 32);

	wire logic hit_cfg = (waddr == pmia_pkg::OFF_CFG);
	wire logic hit_ceid_lo = (waddr == pmia_pkg::OFF_CEID_LO);
	wire logic hit_auth = (waddr == pmia_pkg::OFF_AUTH);
	wire logic hit_devtype = (waddr == pmia_pkg::OFF_DEVTYPE);
	wire logic hit_ident = (waddr >= pmia_pkg::OFF_IDENT_LO) &&
		(waddr <= pmia_pkg::OFF_IDENT_HI);

	// identity word k reads base plus k
	wire logic [15:0] ident_off = waddr - pmia_pkg::OFF_IDENT_LO;
	wire logic [31:0] ident_word = IDENT_BASE + {18'h0, ident_off[15:2]};

	// bank read words, set and clear views show the same state
	wire logic [31:0] ce_word = count_enable[widx*32 +: 32];
	wire logic [31:0] ie_word = irq_enable[widx*32 +: 32];
	wire logic [31:0] ov_word = overflow_status[widx*32 +: 32];

	// read-only words
	wire logic [31:0] cfg_word = {16'h0000, 2'b00, pmia_pkg::CFG_SIZE,
		CNT_N};
	wire logic [31:0] ceid_lo_word =
		EVENT_IMPL & pmia_pkg::CEID0_MASK;

	// everything not listed, including the high event id word,
	// the integration slot and the page tail, reads zero
	always_comb begin
		next_rdata = pmia_pkg::RDATA_RST;
		if (rd_req) begin
			if (hit_ce) begin
				next_rdata = ce_word;
			end else if (hit_ie) begin
				next_rdata = ie_word;
			end else if (hit_ov) begin
				next_rdata = ov_word;
			end else if (hit_cfg) begin
				next_rdata = cfg_word;
			end else if (hit_ceid_lo) begin
				next_rdata = ceid_lo_word;
			end else if (hit_auth) begin
				next_rdata = auth_status;
			end else if (hit_devtype) begin
				next_rdata = DEV_TYPE;
			end else if (hit_ident) begin
				next_rdata = ident_word;
			end
		end
	end

	// every access is answered one cycle later, none with an error
	always_ff @(posedge mclk) begin
		if (rst) begin
			reg_rdata <= pmia_pkg::RDATA_RST;
			reg_ack <= 1'b0;
		end else begin
			reg_rdata <= next_rdata;
			reg_ack <= reg_req.sel;
		end
	end

	// bitmap banks
	pmia_bitmap u_count_enable (
		.mclk(mclk),
		.rst(rst),
		.cnt_n(CNT_N),
		.set_wr(wr_ce_set),
		.clr_wr(wr_ce_clr),
		.word_idx(widx),
		.wdata(reg_req.wdata),
		.hw_set('0),
		.bits(count_enable)
	);

	pmia_bitmap u_irq_enable (
		.mclk(mclk),
		.rst(rst),
		.cnt_n(CNT_N),
		.set_wr(wr_ie_set),
		.clr_wr(wr_ie_clr),
		.word_idx(widx),
		.wdata(reg_req.wdata),
		.hw_set('0),
		.bits(irq_enable)
	);

	// counter overflow events set status; they win over a clear
	pmia_bitmap u_overflow (
		.mclk(mclk),
		.rst(rst),
		.cnt_n(CNT_N),
		.set_wr(wr_ov_set),
		.clr_wr(wr_ov_clr),
		.word_idx(widx),
		.wdata(reg_req.wdata),
		.hw_set(ovf_event),
		.bits(overflow_status)
	);

	pmia_auth #(
		.SEC_EXT(SEC_EXT)
	) u_auth (
		.mclk(mclk),
		.rst(rst),
		.dbg_allow_in(dbg_allow_in),
		.watch_allow_in(watch_allow_in),
		.trusted_dbg_allow_in(trusted_dbg_allow_in),
		.trusted_watch_allow_in(trusted_watch_allow_in),
		.status(auth_status)
	);

	// read checks
	cfg_read_a:
	assert property (@(posedge mclk) disable iff (rst)
		(rd_req && waddr == pmia_pkg::OFF_CFG)
		|=> reg_ack && reg_rdata[7:0] == CNT_N
		&& reg_rdata[13:8] == 6'h1f)
		else $error("configuration word wrong");

	ceid_lo_a:
	assert property (@(posedge mclk) disable iff (rst)
		(rd_req && waddr == 16'h0e20)
		|=> reg_ack && reg_rdata[31:19] == '0
		&& reg_rdata[18] == EVENT_IMPL[18]
		&& reg_rdata[7:2] == '0)
		else $error("event id low word wrong");

	ceid_bits_a:
	assert property (@(posedge mclk) disable iff (rst)
		(rd_req && waddr == 16'h0e20)
		|=> reg_rdata[17:16] == EVENT_IMPL[17:16]
		&& reg_rdata[10:8] == EVENT_IMPL[10:8]
		&& reg_rdata[1:0] == EVENT_IMPL[1:0]
		&& reg_rdata[15:11] == '0)
		else $error("event class bits wrong");

	ceid_hi_a:
	assert property (@(posedge mclk) disable iff (rst)
		(rd_req && waddr == 16'h0e24) |=> reg_ack && reg_rdata == '0)
		else $error("event id high word not zero");

	resv_read_a:
	assert property (@(posedge mclk) disable iff (rst)
		(rd_req && ((waddr >= 16'h0e28 && waddr <= 16'h0e7c)
		|| (waddr >= 16'h0f00 && waddr <= 16'h0fb4)))
		|=> reg_ack && reg_rdata == '0)
		else $error("reserved word not zero");

	auth_hole_a:
	assert property (@(posedge mclk) disable iff (rst)
		(rd_req && waddr >= 16'h0fbc && waddr <= 16'h0fc8)
		|=> reg_ack && reg_rdata == '0)
		else $error("reserved word after auth not zero");

	page_tail_a:
	assert property (@(posedge mclk) disable iff (rst)
		(rd_req && waddr >= 16'h1000) |=> reg_ack && reg_rdata == '0)
		else $error("page tail not zero");

	ident_read_a:
	assert property (@(posedge mclk) disable iff (rst)
		(rd_req && waddr == 16'h0fd0) |=> reg_rdata == IDENT_BASE)
		else $error("first identity word wrong");

	devtype_read_a:
	assert property (@(posedge mclk) disable iff (rst)
		(rd_req && waddr == 16'h0fcc) |=> reg_rdata == DEV_TYPE)
		else $error("device type word wrong");

	auth_fixed_a:
	assert property (@(posedge mclk) disable iff (rst)
		(rd_req && waddr == 16'h0fb8 && !$past(rst))
		|=> reg_rdata[31:7] == 25'h1
		&& reg_rdata[5:4] == 2'b00 && reg_rdata[1:0] == 2'b00)
		else $error("fixed auth bits wrong");

	bank_alias_a:
	assert property (@(posedge mclk) disable iff (rst)
		(rd_req && (hit_ce || hit_ie || hit_ov) && widx > 3'(CNT_N / 32))
		|=> reg_ack && reg_rdata == '0)
		else $error("bitmap word above top instance not zero");

	ack_every_a:
	assert property (@(posedge mclk) disable iff (rst)
		reg_req.sel |=> reg_ack ##1 (reg_ack == $past(reg_req.sel)))
		else $error("access not answered");

	// answer checks
	wr_quiet_a:
	assert property (@(posedge mclk) disable iff (rst)
		wr_req |=> reg_ack && reg_rdata == '0)
		else $error("write answered with data");

	idle_quiet_a:
	assert property (@(posedge mclk) disable iff (rst)
		!reg_req.sel |=> !reg_ack && reg_rdata == '0)
		else $error("answer without a request");

	ident_last_a:
	assert property (@(posedge mclk) disable iff (rst)
		(rd_req && waddr == pmia_pkg::OFF_IDENT_HI)
		|=> reg_rdata == IDENT_BASE + 32'h0000_000b)
		else $error("last identity word wrong");

	auth_read_a:
	assert property (@(posedge mclk) disable iff (rst)
		(rd_req && hit_auth) |=> reg_rdata == $past(auth_status))
		else $error("auth status not returned");

	// bank view checks
	ce_read_a:
	assert property (@(posedge mclk) disable iff (rst)
		(rd_req && hit_ce) |=> reg_rdata == $past(ce_word))
		else $error("count enable word not returned");

	ie_read_a:
	assert property (@(posedge mclk) disable iff (rst)
		(rd_req && hit_ie) |=> reg_rdata == $past(ie_word))
		else $error("irq enable word not returned");

	ov_read_a:
	assert property (@(posedge mclk) disable iff (rst)
		(rd_req && hit_ov) |=> reg_rdata == $past(ov_word))
		else $error("overflow word not returned");

	// write side checks
	bank_ro_a:
	assert property (@(posedge mclk) disable iff (rst)
		(wr_req && !hit_ce && !hit_ie && !hit_ov)
		|=> $stable(count_enable) && $stable(irq_enable))
		else $error("write outside the banks changed state");

	ce_absent_a:
	assert property (@(posedge mclk) disable iff (rst)
		(wr_ce_set && widx > top_word) |=> $stable(count_enable))
		else $error("write to absent count enable word took");

	ie_absent_a:
	assert property (@(posedge mclk) disable iff (rst)
		(wr_ie_set && widx > top_word) |=> $stable(irq_enable))
		else $error("write to absent irq enable word took");

	ovf_wins_a:
	assert property (@(posedge mclk) disable iff (rst)
		ovf_event[0] |=> overflow_status[0])
		else $error("overflow event lost");
endmodule

// ===== tb_perf_monitor_id_auth_map.sv
// tb_perf_monitor_id_auth_map: self-checking bench for the monitor page.
// assumes pmia_pkg is compiled first and default build parameters.
`timescale 1ns/1ps
module tb_perf_monitor_id_auth_map;
	typedef struct {
		logic wr;
		logic [15:0] a;
		logic [31:0] d;
		logic [31:0] e;
	} pmia_row_t;
	logic mclk;
	logic rst;
	pmia_pkg::pmia_req_t req;
	logic dbg, watch, tdbg, twatch;
	logic [255:0] ovf_event;
	logic [31:0] rdata, rdata_ns, rd, rd_ns;
	logic ack;
	logic [255:0] count_enable, irq_enable, overflow_status, pick;
	int err_count = 0;
	int checks = 0;
	logic [15:0] sb[3] = '{16'h0c00, 16'h0c40, 16'h0cc0};
	logic [15:0] cb[3] = '{16'h0c20, 16'h0c60, 16'h0c80};
	pmia_row_t rows[20] = '{
		'{1'b0, 16'h0e20, 32'h0000_0000, 32'h0007_0703},
		'{1'b1, 16'h0e20, 32'hffff_ffff, 32'h0007_0703},
		'{1'b0, 16'h0e24, 32'h0000_0000, 32'h0000_0000},
		'{1'b1, 16'h0e24, 32'hffff_ffff, 32'h0000_0000},
		'{1'b0, 16'h0e28, 32'h0000_0000, 32'h0000_0000},
		'{1'b1, 16'h0e7c, 32'hffff_ffff, 32'h0000_0000},
		'{1'b0, 16'h0e80, 32'h0000_0000, 32'h0000_0000},
		'{1'b1, 16'h0f00, 32'hffff_ffff, 32'h0000_0000},
		'{1'b0, 16'h0f04, 32'h0000_0000, 32'h0000_0000},
		'{1'b0, 16'h0fb4, 32'h0000_0000, 32'h0000_0000},
		'{1'b1, 16'h0fbc, 32'hffff_ffff, 32'h0000_0000},
		'{1'b0, 16'h0fc8, 32'h0000_0000, 32'h0000_0000},
		'{1'b1, 16'h0fcc, 32'hffff_ffff, 32'h0000_0056},
		'{1'b0, 16'h0fd0, 32'h0000_0000, 32'h0000_00a0},
		'{1'b1, 16'h0ffc, 32'hffff_ffff, 32'h0000_00ab},
		'{1'b1, 16'h1000, 32'hffff_ffff, 32'h0000_0000},
		'{1'b0, 16'hfffc, 32'h0000_0000, 32'h0000_0000},
		'{1'b1, 16'h0e00, 32'hffff_ffff, 32'h0000_1f23},
		'{1'b0, 16'h0ca0, 32'h0000_0000, 32'h0000_0000},
		'{1'b0, 16'h0d80, 32'h0000_0000, 32'h0000_0000}
	};

	pmia_top u_pmia_top (
		.mclk(mclk),
		.rst(rst),
		.reg_req(req),
		.dbg_allow_in(dbg),
		.watch_allow_in(watch),
		.trusted_dbg_allow_in(tdbg),
		.trusted_watch_allow_in(twatch),
		.ovf_event(ovf_event),
		.reg_rdata(rdata),
		.reg_ack(ack),
		.count_enable(count_enable),
		.irq_enable(irq_enable),
		.overflow_status(overflow_status)
	);

	// build without the security extensions, same stimulus
	pmia_top #(.SEC_EXT(1'b0)) u_pmia_top_ns (
		.mclk(mclk),
		.rst(rst),
		.reg_req(req),
		.dbg_allow_in(dbg),
		.watch_allow_in(watch),
		.trusted_dbg_allow_in(tdbg),
		.trusted_watch_allow_in(twatch),
		.ovf_event(ovf_event),
		.reg_rdata(rdata_ns),
		.reg_ack(),
		.count_enable(),
		.irq_enable(),
		.overflow_status()
	);

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic finish_test();
		$display("checks=%0d err_count=%0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// one access: request held over one taking edge, answer one cycle on
	task automatic acc(input logic wr, input logic [15:0] a,
			input logic [31:0] d);
		@(posedge mclk);
		req <= {1'b1, wr, a, d};
		@(posedge mclk);
		req.sel <= 1'b0;
		#1;
		chk({31'h0, ack}, 32'h0000_0001);
		rd = rdata;
		rd_ns = rdata_ns;
	endtask

	initial begin
		logic o, t;
		rst = 1'b1;
		req = '0;
		{dbg, watch, tdbg, twatch} = 4'h0;
		ovf_event = '0;
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		#1;
		chk({31'h0, ack}, 32'h0000_0000);
		chk({31'h0, |{count_enable, irq_enable, overflow_status}},
			32'h0000_0000);
		// map table: decode, read-only and reserved places
		foreach (rows[i]) begin
			acc(rows[i].wr, rows[i].a, rows[i].d);
			if (rows[i].wr) acc(1'b0, rows[i].a, 32'h0000_0000);
			chk(rd, rows[i].e);
		end
		// bitmap banks: full word, partial top word, absent words
		for (int p = 0; p < 3; p++) begin
			acc(1'b1, sb[p], 32'hffff_ffff);
			acc(1'b1, sb[p] + 16'h0004, 32'hffff_ffff);
			acc(1'b1, sb[p] + 16'h0008, 32'hffff_ffff);
			acc(1'b0, sb[p], 32'h0000_0000);
			chk(rd, 32'hffff_ffff);
			acc(1'b0, cb[p] + 16'h0004, 32'h0000_0000);
			chk(rd, 32'h0000_000f);
			acc(1'b0, sb[p] + 16'h0008, 32'h0000_0000);
			chk(rd, 32'h0000_0000);
			acc(1'b1, cb[p], 32'h0000_0001);
			acc(1'b1, cb[p] + 16'h0004, 32'h0000_0008);
			acc(1'b0, sb[p], 32'h0000_0000);
			chk(rd, 32'hffff_fffe);
			pick = p == 0 ? count_enable : p == 1 ? irq_enable
				: overflow_status;
			chk(pick[63:32], 32'h0000_0007);
			chk(pick[31:0], 32'hffff_fffe);
		end
		// hardware overflow: counter 33 exists, counter 40 does not
		acc(1'b1, 16'h0c84, 32'hffff_ffff);
		@(posedge mclk);
		ovf_event <= (256'h1 << 33) | (256'h1 << 40);
		@(posedge mclk);
		ovf_event <= '0;
		#1;
		chk(overflow_status[63:32], 32'h0000_0002);
		// overflow event on the same edge as a clear of the same bit
		@(posedge mclk);
		req <= {1'b1, 1'b1, 16'h0c80, 32'h0000_0001};
		ovf_event <= 256'h1;
		@(posedge mclk);
		req.sel <= 1'b0;
		ovf_event <= '0;
		#1;
		chk(overflow_status[31:0], 32'hffff_ffff);
		// every permission combination, both builds
		for (int k = 0; k < 16; k++) begin
			@(posedge mclk);
			{dbg, watch, tdbg, twatch} <= k[3:0];
			acc(1'b0, 16'h0fb8, 32'h0000_0000);
			o = k[3] | k[2];
			t = o & (k[1] | k[0]);
			chk(rd, {24'h0, 1'b1, t, 2'b0, 1'b1, o, 2'b0});
			chk(rd_ns, {24'h0, 1'b1, o, 6'h0});
		end
		// reset in mid-run empties the banks
		@(posedge mclk);
		rst <= 1'b1;
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		#1;
		chk({31'h0, |{count_enable, irq_enable, overflow_status}},
			32'h0000_0000);
		acc(1'b0, 16'h0c00, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		finish_test();
	end

	initial begin
		repeat (20000) @(posedge mclk);
		err_count++;
		finish_test();
	end
endmodule
